// ### shared/snad_pkg.sv
// constants and carrier types for the series node aux and diagnostic logic
package snad_pkg;

  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned FLASH1_HZ     = 1;
  localparam int unsigned FLASH2_HZ     = 2;
  localparam int unsigned FLASH1_HALF_CYC = CLK_HZ / (2 * FLASH1_HZ);
  localparam int unsigned FLASH2_HALF_CYC = CLK_HZ / (2 * FLASH2_HZ);

  localparam int unsigned NODES_DEF = 8;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ADDR_W    = 8;

  localparam logic [ADDR_W-1:0] OFS_LINE    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_AUX_IN  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_AUX_REQ = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_AUX_OUT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_FLASH1  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FLASH2  = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_MON_DIS = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_COUPLE  = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_SHUT    = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_DYN     = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_STAT    = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_PRES    = 8'h2c;

  localparam logic [DATA_W-1:0] RST_AUX_REQ = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_FLASH   = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_MON_DIS = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_COUPLE  = 32'hffff_ffff;

  localparam int unsigned LINE_SENSOR_BIT = 0;
  localparam int unsigned LINE_ONLINE_BIT = 1;
  localparam int unsigned LINE_BREAK_BIT  = 2;
  localparam int unsigned LINE_SAFE_BIT   = 3;
  localparam int unsigned LINE_VALID_BIT  = 4;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } snad_bus_t;

  typedef struct packed {
    logic online;
    logic cable_break;
  } snad_line_t;

  typedef struct packed {
    logic diag_valid;
    logic safe_ok;
    logic cable_break;
    logic online;
    logic sensor_ok;
  } snad_report_t;

endpackage : snad_pkg

// ### core/snad_aux_out_cell.sv
// one auxiliary output with flashing and output-to-input coupling
`timescale 1ns/100ps
module snad_aux_out_cell #(
  parameter int unsigned HALF1 = snad_pkg::FLASH1_HALF_CYC,
  parameter int unsigned HALF2 = snad_pkg::FLASH2_HALF_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic req,
  input  wire logic mode1,
  input  wire logic mode2,
  input  wire logic coupled,
  input  wire logic aux_in,
  output logic      out
);
  import snad_pkg::*;

  localparam int unsigned CW = $clog2(((HALF1 > HALF2) ? HALF1 : HALF2) + 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] half;
  logic          phase;
  logic          freeze;
  logic          flashing;
  logic          next_out;

  assign freeze   = coupled & aux_in;
  assign flashing = mode1 | mode2;
  // mode 1 wins if software sets both
  assign half     = mode1 ? CW'(HALF1 - 1) : CW'(HALF2 - 1);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt   <= '0;
      phase <= 1'b1;
    end else if (!req || !flashing) begin
      cnt   <= '0;
      phase <= 1'b1;
    end else if (!freeze) begin
      if (cnt >= half) begin
        cnt   <= '0;
        phase <= ~phase;
      end else begin
        cnt   <= cnt + 1'b1;
      end
    end
  end

  assign next_out = req & (flashing ? phase : 1'b1);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      out <= 1'b0;
    end else if (!freeze) begin
      out <= next_out;
    end
  end

  property p_freeze;
    @(posedge ref_clk) disable iff (rst) freeze |=> $stable(out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("output moved while input switched");

  property p_indep;
    @(posedge ref_clk) disable iff (rst) !coupled |=> out == $past(next_out);
  endproperty
  a_indep: assert property (p_indep) else $error("output not independent of input");

  property p_toggle;
    @(posedge ref_clk) disable iff (rst)
      (req && flashing && !freeze && cnt == half) |=> phase != $past(phase);
  endproperty
  a_toggle: assert property (p_toggle) else $error("flash phase did not toggle");

  property p_restart;
    @(posedge ref_clk) disable iff (rst) $rose(req) |-> (cnt == '0 && phase);
  endproperty
  a_restart: assert property (p_restart) else $error("flash phase not restarted");

endmodule : snad_aux_out_cell

// ### core/snad_node_diag.sv
// line status, per-node diagnostics and auxiliary i/o of the series node chain
// Summary of operation
// - aux inputs are sampled and aux outputs driven every clock cycle
// - aux input bit reads 1 when the input is active, else 0
// - aux output bit reads 1 when the output is active, else 0
// - sensor testing bit is 1 only while all present nodes pass their tests
// - online bit follows whether chain communication is running
// - cable break bit is 1 while a link between loop nodes is broken
// - per-node shutdown bit is 1 when no shutdown, while online
// - per-node dynamic test bit drops on discrepancy or sequence error
// - per-node static test bit drops on cross or short circuit
// - per-node presence bit shows whether the node is physically there
// - offline without cable break, per-node diagnostic bits are invalid
// - offline in cable break, presence is 1 only for nodes in the intact part; online, it follows physical presence
// - flashing mode 1 blinks an active aux output at 1 Hz
// - flashing mode 2 blinks an active aux output at 2 Hz
// - by default a switched aux input freezes its node's output and flashing
// - monitoring disable decouples the output; never set it for reset inputs
// - safe line bit is 1 only while no node has shutdown or error
`timescale 1ns/100ps
module snad_node_diag #(
  parameter int unsigned NODES      = snad_pkg::NODES_DEF,
  parameter int unsigned FLASH1_CYC = snad_pkg::FLASH1_HALF_CYC,
  parameter int unsigned FLASH2_CYC = snad_pkg::FLASH2_HALF_CYC
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire snad_pkg::snad_bus_t           bus,
  output logic [snad_pkg::DATA_W-1:0]        rdata,
  input  wire snad_pkg::snad_line_t          line_in,
  input  wire logic [NODES-1:0]              node_shutdown_ok,
  input  wire logic [NODES-1:0]              node_dyn_ok,
  input  wire logic [NODES-1:0]              node_stat_ok,
  input  wire logic [NODES-1:0]              node_present,
  input  wire logic [NODES-1:0]              node_intact,
  input  wire logic [NODES-1:0]              aux_in_pin,
  output logic [NODES-1:0]                   aux_out_pin,
  output snad_pkg::snad_report_t             line_out
);
  import snad_pkg::*;

  function automatic logic [DATA_W-1:0] widen(input logic [NODES-1:0] v);
    widen = DATA_W'(v);
  endfunction : widen

  function automatic logic [NODES-1:0] narrow(input logic [DATA_W-1:0] v);
    narrow = v[NODES-1:0];
  endfunction : narrow

  // polled copies of the chain inputs
  snad_line_t       line_q;
  logic [NODES-1:0] shut_q;
  logic [NODES-1:0] dyn_q;
  logic [NODES-1:0] stat_q;
  logic [NODES-1:0] pres_q;
  logic [NODES-1:0] intact_q;
  logic [NODES-1:0] aux_in_q;

  // software controls
  logic [NODES-1:0] aux_req;
  logic [NODES-1:0] flash1;
  logic [NODES-1:0] flash2;
  logic [NODES-1:0] mon_dis;
  logic [NODES-1:0] couple_en;

  // derived node views
  logic [NODES-1:0] next_shut;
  logic [NODES-1:0] next_dyn;
  logic [NODES-1:0] next_stat;
  logic [NODES-1:0] next_pres;
  logic [NODES-1:0] node_shut_view;
  logic [NODES-1:0] node_dyn_view;
  logic [NODES-1:0] node_stat_view;
  logic [NODES-1:0] node_pres_view;
  snad_report_t     next_line;
  logic [DATA_W-1:0] next_rdata;

  // inputs refreshed every cycle, one flop stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_q   <= '0;
      shut_q   <= '0;
      dyn_q    <= '0;
      stat_q   <= '0;
      pres_q   <= '0;
      intact_q <= '0;
      aux_in_q <= '0;
    end else begin
      line_q   <= line_in;
      shut_q   <= node_shutdown_ok;
      dyn_q    <= node_dyn_ok;
      stat_q   <= node_stat_ok;
      pres_q   <= node_present;
      intact_q <= node_intact;
      aux_in_q <= aux_in_pin;
    end
  end

  // software writes, no wait states
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aux_req   <= RST_AUX_REQ[NODES-1:0];
      flash1    <= RST_FLASH[NODES-1:0];
      flash2    <= RST_FLASH[NODES-1:0];
      mon_dis   <= RST_MON_DIS[NODES-1:0];
      couple_en <= RST_COUPLE[NODES-1:0];
    end else if (bus.wr) begin
      unique case (bus.addr)
        OFS_AUX_REQ: aux_req   <= narrow(bus.wdata);
        OFS_FLASH1:  flash1    <= narrow(bus.wdata);
        OFS_FLASH2:  flash2    <= narrow(bus.wdata);
        OFS_MON_DIS: mon_dis   <= narrow(bus.wdata);
        OFS_COUPLE:  couple_en <= narrow(bus.wdata);
        default: ;
      endcase
    end
  end

  // per-node diagnostics; invalid bits read as zero while offline
  always_comb begin
    next_shut = line_q.online ? shut_q : '0;
    next_dyn  = line_q.online ? dyn_q  : '0;
    next_stat = line_q.online ? stat_q : '0;
    if (line_q.online) begin
      next_pres = pres_q;
    end else if (line_q.cable_break) begin
      next_pres = intact_q;
    end else begin
      next_pres = '0;
    end
  end

  // line level summary
  always_comb begin
    next_line             = '0;
    next_line.online      = line_q.online;
    next_line.cable_break = line_q.cable_break;
    next_line.diag_valid  = line_q.online | line_q.cable_break;
    // a missing node counts as a passing one
    next_line.sensor_ok   = line_q.online & (&((dyn_q & stat_q) | ~pres_q));
    next_line.safe_ok     = line_q.online & ~line_q.cable_break
                            & (&(shut_q & dyn_q & stat_q & pres_q));
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      line_out       <= '0;
      node_shut_view <= '0;
      node_dyn_view  <= '0;
      node_stat_view <= '0;
      node_pres_view <= '0;
    end else begin
      line_out       <= next_line;
      node_shut_view <= next_shut;
      node_dyn_view  <= next_dyn;
      node_stat_view <= next_stat;
      node_pres_view <= next_pres;
    end
  end

  // one output cell per node
  for (genvar n = 0; n < NODES; n++) begin : g_out
    snad_aux_out_cell #(
      .HALF1 (FLASH1_CYC),
      .HALF2 (FLASH2_CYC)
    ) u_cell (
      .ref_clk (ref_clk),
      .rst     (rst),
      .req     (aux_req[n]),
      .mode1   (flash1[n]),
      .mode2   (flash2[n]),
      .coupled (couple_en[n] & ~mon_dis[n]),
      .aux_in  (aux_in_q[n]),
      .out     (aux_out_pin[n])
    );
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = '0;
    unique case (bus.addr)
      OFS_LINE: begin
        next_rdata[LINE_SENSOR_BIT] = line_out.sensor_ok;
        next_rdata[LINE_ONLINE_BIT] = line_out.online;
        next_rdata[LINE_BREAK_BIT]  = line_out.cable_break;
        next_rdata[LINE_SAFE_BIT]   = line_out.safe_ok;
        next_rdata[LINE_VALID_BIT]  = line_out.diag_valid;
      end
      OFS_AUX_IN:  next_rdata = widen(aux_in_q);
      OFS_AUX_REQ: next_rdata = widen(aux_req);
      OFS_AUX_OUT: next_rdata = widen(aux_out_pin);
      OFS_FLASH1:  next_rdata = widen(flash1);
      OFS_FLASH2:  next_rdata = widen(flash2);
      OFS_MON_DIS: next_rdata = widen(mon_dis);
      OFS_COUPLE:  next_rdata = widen(couple_en);
      OFS_SHUT:    next_rdata = widen(node_shut_view);
      OFS_DYN:     next_rdata = widen(node_dyn_view);
      OFS_STAT:    next_rdata = widen(node_stat_view);
      OFS_PRES:    next_rdata = widen(node_pres_view);
      default:     next_rdata = '0;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else begin
      rdata <= bus.rd ? next_rdata : '0;
    end
  end

  property p_poll;
    @(posedge ref_clk) disable iff (rst)
      (bus.rd && bus.addr == OFS_AUX_IN) |=> rdata == widen($past(aux_in_pin, 2));
  endproperty
  a_poll: assert property (p_poll) else $error("aux input read is stale");

  property p_out_read;
    @(posedge ref_clk) disable iff (rst)
      (bus.rd && bus.addr == OFS_AUX_OUT) |=> rdata == widen($past(aux_out_pin));
  endproperty
  a_out_read: assert property (p_out_read) else $error("aux output read mismatch");

  property p_sensor;
    @(posedge ref_clk) disable iff (rst)
      !(&((node_dyn_ok & node_stat_ok) | ~node_present)) |-> ##2 !line_out.sensor_ok;
  endproperty
  a_sensor: assert property (p_sensor) else $error("sensor test bit not cleared");

  property p_online;
    @(posedge ref_clk) disable iff (rst)
      ##2 line_out.online == $past(line_in.online, 2);
  endproperty
  a_online: assert property (p_online) else $error("online bit mismatch");

  property p_break;
    @(posedge ref_clk) disable iff (rst)
      $rose(line_in.cable_break) |-> ##2 line_out.cable_break;
  endproperty
  a_break: assert property (p_break) else $error("cable break not reported");

  property p_shut;
    @(posedge ref_clk) disable iff (rst)
      (line_in.online && !node_shutdown_ok[0]) |-> ##2 !node_shut_view[0] && !line_out.safe_ok;
  endproperty
  a_shut: assert property (p_shut) else $error("shutdown not shown");

  property p_dyn;
    @(posedge ref_clk) disable iff (rst)
      (line_in.online && node_dyn_ok[0]) |-> ##2 node_dyn_view[0];
  endproperty
  a_dyn: assert property (p_dyn) else $error("dynamic test bit wrong");

  property p_stat;
    @(posedge ref_clk) disable iff (rst)
      (line_in.online && node_stat_ok[0]) |-> ##2 node_stat_view[0];
  endproperty
  a_stat: assert property (p_stat) else $error("static test bit wrong");

  property p_pres;
    @(posedge ref_clk) disable iff (rst)
      line_in.online |-> ##2 node_pres_view == $past(node_present, 2);
  endproperty
  a_pres: assert property (p_pres) else $error("presence bit wrong");

  property p_intact;
    @(posedge ref_clk) disable iff (rst)
      (!line_in.online && line_in.cable_break) |-> ##2 node_pres_view == $past(node_intact, 2);
  endproperty
  a_intact: assert property (p_intact) else $error("intact area presence wrong");

  property p_invalid;
    @(posedge ref_clk) disable iff (rst)
      (!line_in.online && !line_in.cable_break) |-> ##2 !line_out.diag_valid;
  endproperty
  a_invalid: assert property (p_invalid) else $error("diagnostics marked valid offline");

  property p_safe;
    @(posedge ref_clk) disable iff (rst)
      line_out.safe_ok |-> $past(&(shut_q & dyn_q & stat_q & pres_q)) && $past(line_q.online);
  endproperty
  a_safe: assert property (p_safe) else $error("safe bit set with a fault");

endmodule : snad_node_diag

// ### test/snad_ctrl_model.sv
// controller-side model: reset pulse qualification on a polled aux input
`timescale 1ns/100ps
module snad_ctrl_model #(
  parameter int unsigned MIN_CYC = 8,
  parameter int unsigned MAX_CYC = 200
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic aux_level,
  input  wire logic diag_valid,
  output logic      diag_use,
  output logic [7:0] accepts
);
  logic [15:0] cnt;
  // node bits are only taken while valid
  assign diag_use = diag_valid;
  // width is measured as seen, so link stretching only lengthens it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt     <= '0;
      accepts <= '0;
    end else if (aux_level) begin
      cnt <= (cnt == 16'hffff) ? cnt : cnt + 16'h1;
    end else begin
      if (cnt >= MIN_CYC && cnt <= MAX_CYC) begin
        accepts <= accepts + 8'h1;
      end
      cnt <= '0;
    end
  end
endmodule : snad_ctrl_model

// ### test/tb.sv
// self-checking bench for the series node aux and diagnostic logic
`timescale 1ns/100ps
module tb;
  import snad_pkg::*;
  logic ref_clk = 0;
  logic rst = 1;
  snad_bus_t bus = '0;
  logic [31:0] rdata;
  snad_line_t line_in = '0;
  logic [7:0] shut = '0, dyn = '0, stat = '0, present = '0, intact = '0, aux_in = '0;
  logic [7:0] aux_out;
  snad_report_t line_out;
  logic ctrl_aux = 0;
  logic diag_use;
  logic [7:0] accepts;
  integer seed = 28;
  int miscompares = 0;
  int num_checks = 0;
  logic [7:0] ofs [4] = '{OFS_SHUT, OFS_DYN, OFS_STAT, OFS_PRES};

  always #50 ref_clk = ~ref_clk;

  // short flash counts keep the blink checks brief
  snad_node_diag #(.NODES(8), .FLASH1_CYC(8), .FLASH2_CYC(4)) i_snad_node_diag (
    .ref_clk(ref_clk), .rst(rst), .bus(bus), .rdata(rdata), .line_in(line_in),
    .node_shutdown_ok(shut), .node_dyn_ok(dyn), .node_stat_ok(stat), .node_present(present),
    .node_intact(intact), .aux_in_pin(aux_in), .aux_out_pin(aux_out), .line_out(line_out));

  snad_ctrl_model #(.MIN_CYC(8), .MAX_CYC(200)) i_snad_ctrl_model (
    .ref_clk(ref_clk), .rst(rst), .aux_level(ctrl_aux), .diag_valid(line_out.diag_valid),
    .diag_use(diag_use), .accepts(accepts));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus.wr    <= 1'b1;
    bus.addr  <= a;
    bus.wdata <= d;
    @(posedge ref_clk);
    bus.wr    <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    bus.rd   <= 1'b1;
    bus.addr <= a;
    @(posedge ref_clk);
    bus.rd   <= 1'b0;
    @(negedge ref_clk);
    d = rdata;
    if (a == OFS_AUX_IN) ctrl_aux = d[2];
  endtask : rd

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(n, e, d);
  endtask : rchk

  function automatic snad_report_t exp_rep();
    snad_report_t r;
    r.online      = line_in.online;
    r.cable_break = line_in.cable_break;
    r.sensor_ok   = line_in.online & (&((dyn & stat) | ~present));
    r.safe_ok     = line_in.online & ~line_in.cable_break & (&present) & (&shut) & (&dyn) & (&stat);
    r.diag_valid  = line_in.online | line_in.cable_break;
    return r;
  endfunction : exp_rep

  function automatic logic [31:0] exp_view(input int k);
    logic [7:0] v;
    v = '0;
    if (line_in.online) v = (k == 0) ? shut : (k == 1) ? dyn : (k == 2) ? stat : present;
    else if (line_in.cable_break && k == 3) v = intact;
    return {24'h0, v};
  endfunction : exp_view

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    stop_test();
  end

  initial begin
    int st;
    int h;
    logic [7:0] acc;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rchk("aux_req rst", OFS_AUX_REQ, 32'h0);
    rchk("flash1 rst", OFS_FLASH1, 32'h0);
    rchk("flash2 rst", OFS_FLASH2, 32'h0);
    rchk("mon_dis rst", OFS_MON_DIS, 32'h0);
    rchk("couple rst", OFS_COUPLE, 32'h0000_00ff);
    wr(OFS_COUPLE, 32'hffff_ffa5);
    rchk("couple rw", OFS_COUPLE, 32'h0000_00a5);
    wr(OFS_COUPLE, 32'h0000_00ff);
    rchk("unmapped", 8'h30, 32'h0);
    wr(OFS_LINE, 32'hffff_ffff);
    // random diagnostics; first three pin online, offline and broken states
    for (int i = 0; i < 16; i++) begin
      st = (i < 3) ? i : {$random(seed)} % 3;
      @(posedge ref_clk);
      line_in.online      <= (st == 0);
      line_in.cable_break <= (st == 2);
      shut    <= (i == 0) ? 8'hff : 8'($random(seed) | $random(seed));
      dyn     <= (i == 0) ? 8'hff : 8'($random(seed) | $random(seed));
      stat    <= (i == 0) ? 8'hff : 8'($random(seed) | $random(seed));
      present <= (i == 0) ? 8'hff : 8'($random(seed) | $random(seed));
      intact  <= 8'($random(seed));
      aux_in  <= 8'($random(seed));
      repeat (3) @(posedge ref_clk);
      #1;
      chk("line_out", {27'h0, exp_rep()}, {27'h0, line_out});
      chk("diag_use", {31'h0, line_in.online | line_in.cable_break}, {31'h0, diag_use});
      rchk("line reg", OFS_LINE, {27'h0, exp_rep()});
      for (int k = 0; k < 4; k++) begin
        rchk("node view", ofs[k], exp_view(k));
      end
      rchk("aux_in", OFS_AUX_IN, {24'h0, aux_in});
    end
    @(posedge ref_clk);
    aux_in <= 8'h02;
    repeat (3) @(posedge ref_clk);
    wr(OFS_AUX_REQ, 32'h0000_000a);
    repeat (3) @(posedge ref_clk);
    #1;
    chk("frozen out", 32'h8, {24'h0, aux_out});
    // node 2 serves as reset input, so only node 1 is decoupled
    wr(OFS_MON_DIS, 32'h0000_0002);
    repeat (3) @(posedge ref_clk);
    rchk("aux_out", OFS_AUX_OUT, 32'h0000_000a);
    wr(OFS_MON_DIS, 32'h0);
    wr(OFS_AUX_REQ, 32'h0);
    @(posedge ref_clk);
    aux_in <= 8'h00;
    for (int m = 1; m <= 2; m++) begin
      h = (m == 1) ? 8 : 4;
      wr((m == 1) ? OFS_FLASH1 : OFS_FLASH2, 32'h1);
      wr(OFS_AUX_REQ, 32'h1);
      for (int i = 0; i < 4 * h; i++) begin
        @(posedge ref_clk);
        #1;
        chk("flash", {31'h0, ((i / h) % 2) == 0}, {31'h0, aux_out[0]});
      end
      wr(OFS_AUX_REQ, 32'h0);
      wr((m == 1) ? OFS_FLASH1 : OFS_FLASH2, 32'h0);
    end
    // random aux reads may have left a pulse open; close it and count from here
    @(negedge ref_clk);
    ctrl_aux = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    acc = accepts;
    // reset pulses seen through polling: one too short, one long enough
    for (int p = 2; p <= 8; p += 6) begin
      @(posedge ref_clk);
      aux_in <= 8'h04;
      repeat (p) rd(OFS_AUX_IN, h);
      @(posedge ref_clk);
      aux_in <= 8'h00;
      repeat (3) rd(OFS_AUX_IN, h);
    end
    chk("accepts", {24'h0, acc + 8'h1}, {24'h0, accepts});
    stop_test();
  end
endmodule : tb
